// ===== common/mcuic_pkg.sv
// Purpose: constants and types for the microcontroller interrupt controller
// Assumes: classic wishbone, 8-bit data in the low byte of 32-bit words
// Notes:   offsets are byte addresses, four times the printed register index
// Operation
// R1 - global enable passes unmasked requests, else blocks
// R2 - reset clears global enable
// R3 - return from handler sets global enable
// R4 - vector clears global enable, pushes, loads 0004h
// R5 - flags set regardless of enables
// R6 - clearing global enable defers pending requests; in ST_WAKE, core_clr_gie with next_executed still takes the vector
// R7 - external events vector within three or four cycles
// R8 - external pin edge selected by option bit 6
// R9 - external pin enable bit 4 gates it
// R10 - enabled pin edge wakes sleep, vector needs global
// R11 - timer wrap sets bit 2, enable bit 5
// R12 - enabled pin change sets bit 0, enable bit 3
// R13 - change coinciding with port read may miss
// R14 - peripheral flags and enables, reset 000- 0000
// R15 - software clears serviced flags before re-enabling
// R16 - after wake execute next instruction, then vector
// R17 - wake leaves registers unchanged except cause flags
// R18 - peripheral requests also need peripheral enable
// R19 - request is OR of flag and enable terms
package mcuic_pkg;
    localparam logic [9:0]  IDX_ICTL     = 10'h00B;
    localparam logic [9:0]  IDX_PFLG     = 10'h00C;
    localparam logic [9:0]  IDX_PEN      = 10'h08C;
    localparam logic [9:0]  IDX_OPTION   = 10'h081;
    localparam logic [9:0]  IDX_IOC      = 10'h096;
    localparam logic [9:0]  IDX_CORE     = 10'h100;
    localparam logic [9:0]  IDX_SR       = 10'h101;
    localparam logic [9:0]  IDX_SCLR     = 10'h102;
    localparam logic [9:0]  IDX_SEN      = 10'h103;
    localparam logic [7:0]  ICTL_RST     = 8'h00;
    localparam logic [7:0]  PFLG_RST     = 8'h00;
    localparam logic [7:0]  PFLG_MASK    = 8'hEF;
    localparam logic [7:0]  OPTION_RST   = 8'hFF;
    localparam logic [5:0]  IOC_RST      = 6'h00;
    localparam int          B_GIE        = 7;
    localparam int          B_PIE        = 6;
    localparam int          B_TIMER_ZERO_IRQ_ENABLE       = 5;
    localparam int          B_EXTIE      = 4;
    localparam int          B_PCIE       = 3;
    localparam int          B_T0F        = 2;
    localparam int          B_EXTF       = 1;
    localparam int          B_PCF        = 0;
    localparam int          B_EDGE       = 6;
    localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
    localparam logic [1:0]  LAT_CYCLES   = 2'h2;
    typedef struct packed {
        logic       take;
        logic [12:0] vector;
        logic       wake;
    } mcuic_core_t;
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_SYNC  = 4'h2,
        ST_SLEEP = 4'h4,
        ST_WAKE  = 4'h8
    } mcuic_state_t;
endpackage : mcuic_pkg

// ===== rtl/mcuic_top.sv
// Purpose: interrupt flags, enables, vectoring and wake-up for an 8-bit core
// Assumes: core pulses are one clock wide and on this clock
// Notes:   pins pass two flip-flops before any logic reads them
`timescale 1ns/1ps
module mcuic_top (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // event sources
    input  wire logic        ext_irq_pin,
    input  wire logic [5:0]  port_pins,
    input  wire logic        port_read,
    input  wire logic        timer_zero_wrap,
    input  wire logic [7:0]  periph_events,
    // core sequencer
    input  wire logic        return_from_handler,
    input  wire logic        core_clr_gie,
    input  wire logic        core_sleep,
    input  wire logic        next_executed,
    output logic             core_irq_take,
    output logic      [12:0] core_vector,
    output logic             core_wake,
    // summary interrupt
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  ictl, next_ictl;
    logic [7:0]  pflg, next_pflg;
    logic [7:0]  pen, next_pen;
    logic [7:0]  option, next_option;
    logic [5:0]  pin_change_enables, next_ioc;
    logic [2:0]  sr, next_sr;
    logic [2:0]  sen, next_sen;
    logic        ext_s1, ext_s2, ext_d;
    logic [5:0]  pin_s1, pin_s2, pin_d;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        ext_edge, pc_evt, pending, wake_cond;
    logic [1:0]  lat, next_lat;
    mcuic_pkg::mcuic_state_t st, next_st;
    mcuic_pkg::mcuic_core_t  cout, next_cout;
    logic        next_irq;
    logic        wr, rd;
    logic [9:0]  idx;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_d  <= 1'b0;
            pin_s1 <= 6'h00;
            pin_s2 <= 6'h00;
            pin_d  <= 6'h00;
        end else begin
            ext_s1 <= ext_irq_pin;
            ext_s2 <= ext_s1;
            ext_d  <= ext_s2;
            pin_s1 <= port_pins;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    always_comb begin
        // edge polarity from option bit
        ext_edge = option[mcuic_pkg::B_EDGE] ? (ext_s2 & ~ext_d) : (~ext_s2 & ext_d); // R8
        // a change seen during a port read is dropped, as the core does
        pc_evt = (|((pin_s2 ^ pin_d) & pin_change_enables)) & ~port_read; // R12 R13
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    always_comb begin
        idx = wb_adr_i[11:2];
        wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
        rd  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = 32'h0000_0000;
        if (rd) begin
            case (idx)
                mcuic_pkg::IDX_ICTL:   next_dat[7:0] = ictl;
                mcuic_pkg::IDX_PFLG:   next_dat[7:0] = pflg;
                mcuic_pkg::IDX_PEN:    next_dat[7:0] = pen;
                mcuic_pkg::IDX_OPTION: next_dat[7:0] = option;
                mcuic_pkg::IDX_IOC:    next_dat[5:0] = pin_change_enables;
                mcuic_pkg::IDX_CORE:   next_dat[3:0] = st;
                mcuic_pkg::IDX_SR:     next_dat[2:0] = sr;
                mcuic_pkg::IDX_SEN:    next_dat[2:0] = sen;
                default:               next_dat = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and flags; hardware set wins over software clear
    always_comb begin
        next_ictl   = ictl;
        next_pflg   = pflg;
        next_pen    = pen;
        next_option = option;
        next_ioc    = pin_change_enables;
        next_sen    = sen;
        next_sr     = sr;
        if (wr) begin
            case (idx)
                mcuic_pkg::IDX_ICTL:   next_ictl = wb_dat_i[7:0];
                mcuic_pkg::IDX_PFLG:   next_pflg = wb_dat_i[7:0] & mcuic_pkg::PFLG_MASK;
                mcuic_pkg::IDX_PEN:    next_pen = wb_dat_i[7:0] & mcuic_pkg::PFLG_MASK; // R14
                mcuic_pkg::IDX_OPTION: next_option = wb_dat_i[7:0];
                mcuic_pkg::IDX_IOC:    next_ioc = wb_dat_i[5:0];
                mcuic_pkg::IDX_SCLR:   next_sr = sr & ~wb_dat_i[2:0];
                mcuic_pkg::IDX_SEN:    next_sen = wb_dat_i[2:0];
                default:               next_sen = sen;
            endcase
        end
        // flags set whatever the enables; only event bits change on wake
        if (ext_edge) next_ictl[mcuic_pkg::B_EXTF] = 1'b1; // R5 R8 R17
        if (timer_zero_wrap) next_ictl[mcuic_pkg::B_T0F] = 1'b1; // R5 R11
        if (pc_evt) next_ictl[mcuic_pkg::B_PCF] = 1'b1; // R5 R12
        next_pflg = next_pflg | (periph_events & mcuic_pkg::PFLG_MASK); // R5 R14
        if (return_from_handler) next_ictl[mcuic_pkg::B_GIE] = 1'b1; // R3
        if (core_clr_gie | (cout.take == 1'b0 && next_cout.take)) begin
            next_ictl[mcuic_pkg::B_GIE] = 1'b0; // R4 R6
        end
        next_sr = next_sr | {cout.take == 1'b0 && next_cout.take, st == mcuic_pkg::ST_WAKE, ext_edge};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ictl     <= mcuic_pkg::ICTL_RST; // R2
            pflg     <= mcuic_pkg::PFLG_RST; // R14
            pen      <= mcuic_pkg::PFLG_RST;
            option   <= mcuic_pkg::OPTION_RST;
            pin_change_enables      <= mcuic_pkg::IOC_RST;
            sr       <= 3'h0;
            sen      <= 3'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ictl     <= next_ictl;
            pflg     <= next_pflg;
            pen      <= next_pen;
            option   <= next_option;
            pin_change_enables      <= next_ioc;
            sr       <= next_sr;
            sen      <= next_sen;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request combine
    always_comb begin
        pending = (ictl[mcuic_pkg::B_T0F] & ictl[mcuic_pkg::B_TIMER_ZERO_IRQ_ENABLE])  // R11 R19
                | (ictl[mcuic_pkg::B_EXTF] & ictl[mcuic_pkg::B_EXTIE]) // R9
                | (ictl[mcuic_pkg::B_PCF] & ictl[mcuic_pkg::B_PCIE])  // R12
                | ((|(pflg & pen)) & ictl[mcuic_pkg::B_PIE]); // R18 R19
        wake_cond = pending; // R10
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: sync stage gives a fixed latency whatever the instruction
    always_comb begin
        next_st   = st;
        next_lat  = lat;
        next_cout = cout;
        next_cout.take   = 1'b0;
        next_cout.wake   = 1'b0;
        next_cout.vector = mcuic_pkg::VECTOR_ADDR; // R4
        case (st)
            mcuic_pkg::ST_RUN: begin
                if (core_sleep) begin
                    next_st = mcuic_pkg::ST_SLEEP;
                end else if (pending & ictl[mcuic_pkg::B_GIE] & ~core_clr_gie) begin // R1 R6
                    next_st  = mcuic_pkg::ST_SYNC;
                    next_lat = mcuic_pkg::LAT_CYCLES;
                end
            end
            mcuic_pkg::ST_SYNC: begin
                if (~ictl[mcuic_pkg::B_GIE] | core_clr_gie) begin
                    next_st = mcuic_pkg::ST_RUN; // R6
                end else if (lat == 2'h0) begin
                    next_cout.take = 1'b1; // R4 R7
                    next_st = mcuic_pkg::ST_RUN;
                end else begin
                    next_lat = lat - 2'h1;
                end
            end
            mcuic_pkg::ST_SLEEP: begin
                if (wake_cond) begin
                    next_cout.wake = 1'b1; // R10
                    next_st = mcuic_pkg::ST_WAKE;
                end
            end
            mcuic_pkg::ST_WAKE: begin
                if (next_executed) begin // R16
                    next_cout.take = ictl[mcuic_pkg::B_GIE]; // R10 R16
                    next_st = mcuic_pkg::ST_RUN;
                end
            end
            default: next_st = mcuic_pkg::ST_RUN;
        endcase
        next_irq = |(sr & sen);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st   <= mcuic_pkg::ST_RUN;
            lat  <= 2'h0;
            cout <= '0;
            irq  <= 1'b0;
        end else begin
            st   <= next_st;
            lat  <= next_lat;
            cout <= next_cout;
            irq  <= next_irq;
        end
    end

    always_comb begin
        core_irq_take = cout.take;
        core_vector   = cout.vector;
        core_wake     = cout.wake;
    end
endmodule : mcuic_top

// ===== verification/mcuic_sva.sv
// Purpose: port-level checks for the interrupt controller
// Assumes: core pulses are one clock wide
// Notes:   handler and wake phases are tracked from the core pulses
`timescale 1ns/1ps
module mcuic_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic        wb_ack_o,
    // core
    input wire logic        return_from_handler,
    input wire logic        core_clr_gie,
    input wire logic        next_executed,
    input wire logic        core_irq_take,
    input wire logic [12:0] core_vector,
    input wire logic        core_wake
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic in_h;
    logic waking;
    wire logic wr_ictl = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (wb_adr_i == 12'h02C);
    ////////////////////////////////////////////////////////////////////////////////
    // any bus write to the control register at 02Ch also ends the handler, as software may set global enable that way
    always_ff @(posedge clock) begin
        if (rst) begin
            in_h   <= 1'b0;
            waking <= 1'b0;
        end else begin
            in_h   <= core_irq_take | (in_h & ~return_from_handler & ~wr_ictl);
            waking <= core_wake | (waking & ~next_executed);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a single ack");
    property p_vec; core_irq_take |-> core_vector == 13'h0004; endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_take_once; core_irq_take |=> !core_irq_take; endproperty
    a_take_once: assert property (p_take_once) else $error("take longer than one cycle");
    property p_no_retake; core_irq_take |-> !in_h; endproperty
    a_no_retake: assert property (p_no_retake) else $error("take inside handler");
    property p_rst_quiet; $fell(rst) |-> !core_irq_take [*5]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("take right after reset");
    property p_defer; core_clr_gie && !core_irq_take |=> !core_irq_take; endproperty
    a_defer: assert property (p_defer) else $error("take after enable cleared");
    property p_wake_first; core_irq_take |-> !waking; endproperty
    a_wake_first: assert property (p_wake_first) else $error("vector before next instruction");
    property p_wake_once; core_wake |=> !core_wake; endproperty
    a_wake_once: assert property (p_wake_once) else $error("wake longer than one cycle");
endmodule : mcuic_sva
bind mcuic_top mcuic_sva u_mcuic_sva (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .return_from_handler(return_from_handler),
    .core_clr_gie(core_clr_gie), .next_executed(next_executed), .core_irq_take(core_irq_take),
    .core_vector(core_vector), .core_wake(core_wake));

// ===== verification/mcuic_core_model.sv
// Purpose: core sequencer stand-in that finishes the post-wake instruction
// Assumes: wake and take are one-cycle pulses
// Notes:   counts takes and wakes for the bench
`timescale 1ns/1ps
module mcuic_core_model (
    // clock and reset
    input wire logic  clock,
    input wire logic  rst,
    // from the controller
    input wire logic  core_wake,
    input wire logic  core_irq_take,
    // to controller and bench
    output logic       next_executed,
    output logic [7:0] takes,
    output logic [7:0] wakes
);
    logic [1:0] dly;
    always @(posedge clock) begin
        if (rst) begin
            dly   <= 2'h0;
            takes <= 8'h00;
            wakes <= 8'h00;
        end else begin
            dly   <= {dly[0], core_wake};
            takes <= takes + {7'h00, core_irq_take};
            wakes <= wakes + {7'h00, core_wake};
        end
    end
    assign next_executed = dly[1];
endmodule : mcuic_core_model

// ===== verification/mcuic_top_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: one byte per bus word
// Notes:   settle waits are generous bounds, not exact latencies
`timescale 1ns/1ps
module mcuic_top_tb;
    logic        clock, rst, cyc, stb, we, ack, pin, nxt, take, wake, irq;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic [5:0]  pp;
    logic [3:0]  cmd;
    logic [7:0]  pev, takes, wakes;
    logic [12:0] vec;
    int          num_errors, samples_checked, cycles;
    // cmd: bit0 timer wrap, bit1 return, bit2 clear enable, bit3 sleep
    mcuic_top u_mcuic_top (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin(pin),
        .port_pins(pp), .port_read(1'b0), .timer_zero_wrap(cmd[0]), .periph_events(pev),
        .return_from_handler(cmd[1]), .core_clr_gie(cmd[2]), .core_sleep(cmd[3]), .next_executed(nxt),
        .core_irq_take(take), .core_vector(vec), .core_wake(wake), .irq(irq));
    mcuic_core_model u_mcuic_core_model (.clock(clock), .rst(rst), .core_wake(wake), .core_irq_take(take),
        .next_executed(nxt), .takes(takes), .wakes(wakes));
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        @(posedge clock);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        // a missing answer is a mismatch, not a silent pass
        if (ack !== 1'b1) begin
            num_errors++;
            $display("Error bus ack expected 1 seen %b", ack);
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rc
    task automatic pl(input logic [3:0] c);
        cmd <= c;
        @(posedge clock);
        cmd <= 4'h0;
    endtask : pl
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_ext();
        wr(12'h02C, 8'h90);
        pin <= 1'b1;
        wt(16);
        chk("takes", 8'h01, takes);
        chk("vector", 8'h04, vec[7:0]);
        rc(12'h02C, 8'h12);
        pl(4'h2);
        wt(16);
        chk("takes", 8'h02, takes);
        rc(12'h404, 8'h05);
        wr(12'h40C, 8'h01);
        wt(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(12'h40C, 8'h00);
        wt(2);
        chk("irq", 8'h00, {7'h00, irq});
        wr(12'h408, 8'h05);
        rc(12'h404, 8'h00);
        wr(12'h02C, 8'h10);
        pin <= 1'b0;
        wt(8);
        rc(12'h02C, 8'h10);
        wr(12'h204, 8'hBF);
        pin <= 1'b1;
        wt(8);
        rc(12'h02C, 8'h10);
        pin <= 1'b0;
        wt(8);
        rc(12'h02C, 8'h12);
    endtask : t_ext
    task automatic t_defer();
        wr(12'h02C, 8'h82);
        wt(16);
        chk("takes", 8'h02, takes);
        wr(12'h02C, 8'h92);
        pl(4'h4);
        wt(16);
        chk("takes", 8'h02, takes);
        pl(4'h2);
        wt(16);
        chk("takes", 8'h03, takes);
    endtask : t_defer
    task automatic t_flags();
        wr(12'h02C, 8'h00);
        pev <= 8'hFF;
        pl(4'h1);
        pev <= 8'h00;
        wt(4);
        rc(12'h02C, 8'h04);
        rc(12'h030, 8'hEF);
        wr(12'h230, 8'h01);
        rc(12'h230, 8'h01);
        wr(12'h02C, 8'h80);
        wt(16);
        chk("takes", 8'h03, takes);
        wr(12'h02C, 8'hC0);
        wt(16);
        chk("takes", 8'h04, takes);
        wr(12'h02C, 8'hA4);
        wt(16);
        chk("takes", 8'h05, takes);
        wr(12'h030, 8'h00);
    endtask : t_flags
    task automatic t_port();
        wr(12'h258, 8'h01);
        wr(12'h02C, 8'h00);
        pp <= 6'h02;
        wt(8);
        rc(12'h02C, 8'h00);
        pp <= 6'h03;
        wt(8);
        rc(12'h02C, 8'h01);
    endtask : t_port
    task automatic t_sleep();
        wr(12'h204, 8'hFF);
        wr(12'h02C, 8'h10);
        pl(4'h8);
        pin <= 1'b1;
        wt(16);
        chk("wakes", 8'h01, wakes);
        chk("takes", 8'h05, takes);
        rc(12'h02C, 8'h12);
        pin <= 1'b0;
        wr(12'h02C, 8'h90);
        pl(4'h8);
        pin <= 1'b1;
        wt(16);
        chk("wakes", 8'h02, wakes);
        chk("takes", 8'h06, takes);
    endtask : t_sleep
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {cyc, stb, we, pin} = 4'h0;
        {adr, wdat, pp, cmd, pev} = 0;
        cycles = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rc(12'h02C, 8'h00);
        rc(12'h030, 8'h00);
        rc(12'h230, 8'h00);
        rc(12'h204, 8'hFF);
        rc(12'h3FC, 8'h00);
        t_ext();
        t_defer();
        t_flags();
        t_port();
        t_sleep();
        end_of_test();
    end
endmodule : mcuic_top_tb
